// ===== logic/uhrst_top.sv
`timescale 1ns/10ps
// Behaviour
// - In high-speed, revert to full-speed 3.0 to 3.125 ms after SE0 starts.
// - After reverting, wait 100 to 875 before sampling bus and chirping.
// - Awake full-speed: start handshake 2.5 to 3000 after SE0 starts.
// - Suspended: need 2.5 us continuous SE0 before handshake; filter shorter SE0.
// - Drive upstream Chirp K for at least 1.0 ms.
// - Finish upstream Chirp K within 7.0 ms of SE0 start.
// - No host chirp after own chirp: full-speed default 1.0 to 2.5 ms later.
// - Host chirp sequence detected: enter high-speed within 500 us.
// - Not high-speed capable: recognise reset after 2.5 to 10000 us SE0.
// - Ready to answer host within 10 ms after reset ends.
// - Full-speed: at least 2 bit times idle between packets.
// - Full-speed: start response within 6.5 bit times of host packet end.
// - Request without data stage, or address set, completes within 50 ms.
// - Each data packet except the last delivered within 500 ms.
// - Last data packet delivered within 50 ms.
module uhrst_top #(
    parameter int US_CYCLES = uhrst_pkg::US_CYC,
    parameter int MS_US = uhrst_pkg::US_PER_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Upstream line state, asynchronous
    input wire uhrst_pkg::uhrst_line_t line,
    input wire logic hs_capable,
    // Suspend state from the hub core
    input wire logic suspended,
    // Speed and reset status
    output logic hs_mode,
    output logic chirp_k_drive,
    output logic bus_reset,
    output logic reset_done,
    output logic dev_ready,
    // Full-speed packet spacing
    input wire logic rx_eop,
    input wire logic tx_eop,
    input wire logic rsp_pending,
    output logic tx_grant,
    output logic rsp_miss,
    // Standard request deadlines
    input wire uhrst_pkg::uhrst_req_t req,
    output logic req_late
);
    import uhrst_pkg::*;

    // Synchronisers
    uhrst_line_t line_s1, line_s2;
    logic cap_s1, cap_s2;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            line_s1 <= '0;
            line_s2 <= '0;
            cap_s1 <= 1'h0;
            cap_s2 <= 1'h0;
        end else begin
            line_s1 <= line;
            line_s2 <= line_s1;
            cap_s1 <= hs_capable;
            cap_s2 <= cap_s1;
        end
    end

    // Microsecond and millisecond ticks
    logic [PRE_W-1:0] us_pre, next_us_pre;
    logic [MSPRE_W-1:0] ms_pre, next_ms_pre;
    logic us_tick, ms_tick;

    always_comb begin
        us_tick = us_pre == PRE_W'(US_CYCLES - 1);
        ms_tick = us_tick && ms_pre == MSPRE_W'(MS_US - 1);
        next_us_pre = us_tick ? '0 : us_pre + PRE_W'(1);
        next_ms_pre = ms_pre;
        if (ms_tick) begin
            next_ms_pre = '0;
        end else if (us_tick) begin
            next_ms_pre = ms_pre + MSPRE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            us_pre <= '0;
            ms_pre <= '0;
        end else begin
            us_pre <= next_us_pre;
            ms_pre <= next_ms_pre;
        end
    end

    // Timers
    uhrst_state_t state, next_state;
    logic [US_TMR_W-1:0] se0_cnt, st_cnt, flt_cnt;
    logic [MS_TMR_W-1:0] rq_cnt;
    logic [GAP_W-1:0] gap_cnt;
    logic [1:0] kj, prev_kj;
    logic flt_clr;

    assign kj = {line_s2.chirp_k, line_s2.chirp_j};
    assign flt_clr = kj != prev_kj || kj == 2'h0 || kj == 2'h3;

    uhrst_tmr #(.W(US_TMR_W)) u_se0_tmr (
        .clk(clk), .rstn(rstn), .clr(!line_s2.se0), .inc(us_tick), .cnt(se0_cnt)
    );
    uhrst_tmr #(.W(US_TMR_W)) u_st_tmr (
        .clk(clk), .rstn(rstn), .clr(state != next_state), .inc(us_tick), .cnt(st_cnt)
    );
    uhrst_tmr #(.W(US_TMR_W)) u_flt_tmr (
        .clk(clk), .rstn(rstn), .clr(flt_clr), .inc(us_tick), .cnt(flt_cnt)
    );
    uhrst_tmr #(.W(MS_TMR_W)) u_rq_tmr (
        .clk(clk), .rstn(rstn), .clr(req.setup || req.data_pkt), .inc(ms_tick), .cnt(rq_cnt)
    );
    uhrst_tmr #(.W(GAP_W)) u_gap_tmr (
        .clk(clk), .rstn(rstn), .clr(rx_eop || tx_eop), .inc(1'h1), .cnt(gap_cnt)
    );

    // Host chirp counting, each filtered chirp counted once
    logic expect_j, next_expect_j, counted, next_counted, hit;
    logic [CHIRP_CNT_W-1:0] chirps, next_chirps;
    logic [1:0] next_prev_kj;

    always_comb begin
        hit = !flt_clr && !counted && flt_cnt >= FILT_TICKS
            && kj == (expect_j ? 2'h1 : 2'h2);
        next_prev_kj = kj;
        next_counted = !flt_clr && (counted || hit);
        next_expect_j = expect_j;
        next_chirps = chirps;
        if (state != ST_HOST_CHIRP) begin
            next_expect_j = 1'h0;
            next_chirps = '0;
        end else if (hit) begin
            next_expect_j = !expect_j;
            next_chirps = chirps + CHIRP_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_kj <= 2'h0;
            counted <= 1'h0;
            expect_j <= 1'h0;
            chirps <= '0;
        end else begin
            prev_kj <= next_prev_kj;
            counted <= next_counted;
            expect_j <= next_expect_j;
            chirps <= next_chirps;
        end
    end

    // Reset and speed detection
    logic se0_long, next_done;

    assign se0_long = line_s2.se0 && se0_cnt >= FILT_TICKS;

    always_comb begin
        next_state = state;
        next_done = 1'h0;
        unique case (state)
            ST_FS_IDLE: begin
                if (!cap_s2 && se0_long) begin
                    next_state = ST_FS_RESET;
                end else if (cap_s2 && suspended && se0_long) begin
                    next_state = ST_CHIRP_K;
                end else if (cap_s2 && line_s2.se0 && se0_cnt >= FS_WAIT_TICKS) begin
                    next_state = ST_CHIRP_K;
                end
            end
            ST_FS_RESET: begin
                if (!line_s2.se0) begin
                    next_state = ST_FS_IDLE;
                    next_done = 1'h1;
                end
            end
            ST_CHIRP_K: begin
                if (st_cnt >= CHIRP_TICKS) begin
                    next_state = ST_HOST_CHIRP;
                end
            end
            ST_HOST_CHIRP: begin
                if (chirps == HOST_CHIRPS) begin
                    next_state = ST_HS_RESET;
                end else if (st_cnt >= FALLBACK_TICKS) begin
                    next_state = ST_FS_RESET;
                end
            end
            ST_HS_RESET: begin
                if (se0_long) begin
                    next_state = ST_HS_IDLE;
                    next_done = 1'h1;
                end
            end
            ST_HS_IDLE: begin
                if (line_s2.se0 && se0_cnt >= REVERT_TICKS) begin
                    next_state = ST_HS_REVERT;
                end
            end
            ST_HS_REVERT: begin
                if (st_cnt >= SETTLE_TICKS) begin
                    next_state = line_s2.se0 ? ST_CHIRP_K : ST_FS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ST_FS_IDLE;
            reset_done <= 1'h0;
        end else begin
            state <= next_state;
            reset_done <= next_done;
        end
    end

    always_comb begin
        hs_mode = state == ST_HS_RESET || state == ST_HS_IDLE;
        chirp_k_drive = state == ST_CHIRP_K;
        bus_reset = state == ST_FS_RESET || state == ST_CHIRP_K
            || state == ST_HOST_CHIRP || state == ST_HS_RESET;
        dev_ready = state == ST_FS_IDLE || state == ST_HS_IDLE;
    end

    // Response window after a host packet
    logic waiting, next_waiting, rsp_late, next_miss;

    always_comb begin
        rsp_late = !hs_mode && gap_cnt >= RSP_MAX_CYC;
        tx_grant = waiting && rsp_pending && !rx_eop
            && (hs_mode || (gap_cnt >= GAP_MIN_CYC && !rsp_late));
        next_miss = waiting && !rx_eop && rsp_late;
        next_waiting = rx_eop || (waiting && !tx_grant && !rsp_late);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            waiting <= 1'h0;
            rsp_miss <= 1'h0;
        end else begin
            waiting <= next_waiting;
            rsp_miss <= next_miss;
        end
    end

    // Request deadline watchdog
    logic rq_active, next_rq_active, late;
    logic [MS_TMR_W-1:0] rq_limit;

    always_comb begin
        if (!req.has_data) begin
            rq_limit = REQ_NODATA_MS;
        end else if (req.final_due) begin
            rq_limit = REQ_LAST_MS;
        end else begin
            rq_limit = REQ_DATA_MS;
        end
        late = rq_active && !req.done && !req.data_pkt && !req.setup && rq_cnt > rq_limit;
        next_rq_active = req.setup || (rq_active && !req.done && !late);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rq_active <= 1'h0;
            req_late <= 1'h0;
        end else begin
            rq_active <= next_rq_active;
            req_late <= late;
        end
    end
endmodule : uhrst_top

// ===== logic/uhrst_pkg.sv
package uhrst_pkg;
    // Clock base
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PS_PER_US = 1000000;
    localparam int US_CYC = PS_PER_US / CLK_PERIOD_PS;
    localparam int US_PER_MS = 1000;
    localparam int FS_BIT_PS = 83333;

    // Counter widths
    localparam int PRE_W = 8;
    localparam int MSPRE_W = 10;
    localparam int US_TMR_W = 22;
    localparam int MS_TMR_W = 10;
    localparam int GAP_W = 8;
    localparam int CHIRP_CNT_W = 3;

    // Times in units of 100 ns
    localparam int T_FILT_HNS = 25;
    localparam int T_FS_WAIT_HNS = 25000;
    localparam int T_REVERT_HNS = 30000;
    localparam int T_SETTLE_HNS = 1000;
    localparam int T_CHIRP_HNS = 10000;
    localparam int T_FALLBACK_HNS = 10000;

    // Least time to microsecond ticks: round up, plus one tick for prescaler phase
    function automatic int ticks_min(input int t_hns);
        return (t_hns + 9) / 10 + 1;
    endfunction : ticks_min

    localparam logic [US_TMR_W-1:0] FILT_TICKS = US_TMR_W'(ticks_min(T_FILT_HNS));
    localparam logic [US_TMR_W-1:0] FS_WAIT_TICKS = US_TMR_W'(ticks_min(T_FS_WAIT_HNS));
    localparam logic [US_TMR_W-1:0] REVERT_TICKS = US_TMR_W'(ticks_min(T_REVERT_HNS));
    localparam logic [US_TMR_W-1:0] SETTLE_TICKS = US_TMR_W'(ticks_min(T_SETTLE_HNS));
    localparam logic [US_TMR_W-1:0] CHIRP_TICKS = US_TMR_W'(ticks_min(T_CHIRP_HNS));
    localparam logic [US_TMR_W-1:0] FALLBACK_TICKS = US_TMR_W'(ticks_min(T_FALLBACK_HNS));

    // Host chirp sequence: K J K J K J
    localparam logic [CHIRP_CNT_W-1:0] HOST_CHIRPS = 3'h6;

    // Full-speed packet spacing
    localparam int GAP_MIN_BITS = 2;
    localparam int RSP_MAX_TENTH_BITS = 65;
    localparam logic [GAP_W-1:0] GAP_MIN_CYC =
        GAP_W'((GAP_MIN_BITS * FS_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [GAP_W-1:0] RSP_MAX_CYC =
        GAP_W'((RSP_MAX_TENTH_BITS * FS_BIT_PS / 10) / CLK_PERIOD_PS);

    // Standard request deadlines in ms
    localparam logic [MS_TMR_W-1:0] REQ_NODATA_MS = 10'h032;
    localparam logic [MS_TMR_W-1:0] REQ_DATA_MS = 10'h1F4;
    localparam logic [MS_TMR_W-1:0] REQ_LAST_MS = 10'h032;

    typedef struct packed {
        logic se0;
        logic chirp_k;
        logic chirp_j;
    } uhrst_line_t;

    typedef struct packed {
        logic setup;
        logic has_data;
        logic data_pkt;
        logic final_due;
        logic done;
    } uhrst_req_t;

    typedef enum {
        ST_FS_IDLE,
        ST_FS_RESET,
        ST_CHIRP_K,
        ST_HOST_CHIRP,
        ST_HS_RESET,
        ST_HS_IDLE,
        ST_HS_REVERT
    } uhrst_state_t;
endpackage : uhrst_pkg

// ===== logic/uhrst_tmr.sv
`timescale 1ns/10ps
module uhrst_tmr #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic clr,
    input wire logic inc,
    // Count, saturating
    output logic [W-1:0] cnt
);
    logic [W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (clr) begin
            next_cnt = '0;
        end else if (inc && cnt != '1) begin
            next_cnt = cnt + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule : uhrst_tmr

// ===== verification/uhrst_chk.sv
`timescale 1ns/10ps
module uhrst_chk #(
    parameter int US_CYCLES = 2,
    parameter int MS_US = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Line and status
    input wire uhrst_pkg::uhrst_line_t line,
    input wire logic suspended,
    input wire logic hs_mode,
    input wire logic chirp_k_drive,
    input wire logic bus_reset,
    input wire logic reset_done,
    input wire logic dev_ready,
    // Packets and requests
    input wire logic rx_eop,
    input wire logic tx_eop,
    input wire logic rsp_pending,
    input wire logic tx_grant,
    input wire uhrst_pkg::uhrst_req_t req,
    input wire logic req_late
);
    import uhrst_pkg::*;
    // Cycles since line left idle, in chirp, since request step, since packet end
    logic [31:0] sc, kc, rc, next_sc, next_kc, next_rc;
    logic [7:0] gc, next_gc;
    int lim;
    always_comb begin
        next_sc = (line == '0) ? 32'h0 : sc + 32'(sc != 32'hFFFFFFFF);
        next_kc = chirp_k_drive ? kc + 32'h1 : 32'h0;
        next_rc = (req.setup || req.data_pkt) ? 32'h0 : rc + 32'(rc != 32'hFFFFFFFF);
        next_gc = (rx_eop || tx_eop) ? 8'h00 : gc + 8'(gc != 8'hFF);
        lim = (req.has_data && !req.final_due) ? 499 : 49;
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {sc, kc, rc, gc} <= '0;
        end else begin
            {sc, kc, rc, gc} <= {next_sc, next_kc, next_rc, next_gc};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chirp_min_a: assert property ($fell(chirp_k_drive) |-> kc >= 1000 * US_CYCLES)
        else $error("chirp too short");
    chirp_end_a: assert property ($fell(chirp_k_drive) |-> sc <= 7000 * US_CYCLES)
        else $error("chirp ends late");
    fs_wait_a: assert property ($rose(chirp_k_drive) && !suspended |-> sc >= 2500 * US_CYCLES)
        else $error("chirp starts early");
    susp_filt_a: assert property ($rose(chirp_k_drive) |-> sc >= 5 * US_CYCLES / 2)
        else $error("short SE0 not filtered");
    hs_revert_a: assert property ($fell(hs_mode) && !bus_reset |->
        sc >= 3000 * US_CYCLES && sc <= 3125 * US_CYCLES)
        else $error("revert time wrong");
    done_ready_a: assert property (reset_done |-> dev_ready && !bus_reset && !chirp_k_drive)
        else $error("not ready after reset");
    gap_min_a: assert property (tx_grant && !hs_mode |-> gc >= GAP_MIN_CYC)
        else $error("gap too short");
    rsp_max_a: assert property (tx_grant |-> rsp_pending && gc < RSP_MAX_CYC)
        else $error("response too late");
    req_late_a: assert property (req_late |-> rc >= lim * MS_US * US_CYCLES)
        else $error("deadline flagged early");
endmodule : uhrst_chk
bind uhrst_top uhrst_chk #(.US_CYCLES(US_CYCLES), .MS_US(MS_US)) u_chk (
    .clk(clk), .rstn(rstn), .line(line), .suspended(suspended), .hs_mode(hs_mode),
    .chirp_k_drive(chirp_k_drive), .bus_reset(bus_reset), .reset_done(reset_done),
    .dev_ready(dev_ready), .rx_eop(rx_eop), .tx_eop(tx_eop), .rsp_pending(rsp_pending),
    .tx_grant(tx_grant), .req(req), .req_late(req_late));

// ===== verification/uhrst_host.sv
`timescale 1ns/10ps
module uhrst_host #(
    parameter int HOLD = 14
) (
    // Clock
    input wire logic clk,
    // Hub status and bench control
    input wire logic chirp_k_drive,
    input wire logic rst_req,
    input wire logic answer,
    // Upstream line state
    output uhrst_pkg::uhrst_line_t line
);
    import uhrst_pkg::*;
    logic [1:0] kj = 2'h0;
    // Host holds SE0 while resetting, except while it chirps
    assign line = {rst_req && kj == 2'h0, kj};
    // Answer the hub chirp with K J K J K J, each long enough to pass the filter
    always @(negedge chirp_k_drive) begin
        if (answer) begin
            for (int i = 0; i < 6; i++) begin
                @(posedge clk);
                kj <= i[0] ? 2'h1 : 2'h2;
                repeat (HOLD - 1) @(posedge clk);
            end
            @(posedge clk);
            kj <= 2'h0;
        end
    end
endmodule : uhrst_host

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("Error %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_top;
    import uhrst_pkg::*;
    localparam int UC = 2;
    logic clk = 1'b0;
    logic rstn = 1'b0, hs_capable = 1'b1, suspended = 1'b0, rst_req = 1'b0, answer = 1'b0;
    logic rx_eop = 1'b0, tx_eop = 1'b0, rsp_pending = 1'b0;
    uhrst_req_t req = '0;
    uhrst_line_t line;
    logic hs_mode, chirp_k_drive, bus_reset, reset_done, dev_ready, tx_grant, rsp_miss, req_late;
    int err_total = 0, check_count = 0, n;
    wire [8:0] obs = {bus_reset, req_late, rsp_miss, tx_grant, !hs_mode, reset_done, hs_mode,
        !chirp_k_drive, chirp_k_drive};
    uhrst_top #(.US_CYCLES(UC), .MS_US(4)) DUT (.clk(clk), .rstn(rstn), .line(line),
        .hs_capable(hs_capable), .suspended(suspended), .hs_mode(hs_mode),
        .chirp_k_drive(chirp_k_drive), .bus_reset(bus_reset), .reset_done(reset_done),
        .dev_ready(dev_ready), .rx_eop(rx_eop), .tx_eop(tx_eop), .rsp_pending(rsp_pending),
        .tx_grant(tx_grant), .rsp_miss(rsp_miss), .req(req), .req_late(req_late));
    uhrst_host #(.HOLD(7 * UC)) u_host (.clk(clk), .chirp_k_drive(chirp_k_drive),
        .rst_req(rst_req), .answer(answer), .line(line));
    initial forever #4 clk = ~clk;
    task automatic finish_test();
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // Count edges until the chosen output is high, bounded by lim
    task automatic wt(input int w, input int lim, input logic e = 1'b1);
        n = 0;
        // Outputs are looked at mid-cycle, away from the launching edge
        while (obs[w] !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        `CK(n < lim, e)
    endtask : wt
    task automatic go(input logic r, input logic a, input int cyc);
        @(posedge clk);
        rst_req <= r;
        answer <= a;
        repeat (cyc) @(posedge clk);
    endtask : go
    task automatic rst();
        @(posedge clk);
        rstn <= 1'b0;
        suspended <= 1'b0;
        rst_req <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        `CK({hs_mode, chirp_k_drive, bus_reset, dev_ready, reset_done}, 5'h02)
    endtask : rst
    task automatic t_hs();
        go(1'b1, 1'b1, 0);
        wt(0, 2600 * UC);
        `CK(n >= 2500 * UC, 1'b1)
        wt(1, 1100 * UC);
        `CK(n >= 1000 * UC, 1'b1)
        wt(2, 500 * UC);
        wt(3, 20 * UC);
        `CK(dev_ready, 1'b1)
        go(1'b0, 1'b0, 10);
        go(1'b1, 1'b0, 0);
        wt(4, 3130 * UC);
        `CK(n >= 3000 * UC, 1'b1)
        wt(0, 120 * UC);
        `CK(n >= 100 * UC, 1'b1)
        wt(1, 1100 * UC);
        repeat (1010 * UC) @(posedge clk);
        go(1'b0, 1'b0, 0);
        wt(3, 10);
        `CK(hs_mode, 1'b0)
    endtask : t_hs
    task automatic t_susp();
        @(posedge clk);
        suspended <= 1'b1;
        go(1'b1, 1'b0, 2 * UC);
        go(1'b0, 1'b0, 20 * UC);
        `CK(chirp_k_drive, 1'b0)
        go(1'b1, 1'b0, 0);
        wt(0, 10 * UC);
        rst();
    endtask : t_susp
    task automatic t_nohs();
        @(posedge clk);
        hs_capable <= 1'b0;
        go(1'b1, 1'b0, UC);
        go(1'b0, 1'b0, 10 * UC);
        `CK(bus_reset, 1'b0)
        go(1'b1, 1'b0, 0);
        wt(8, 10 * UC);
        repeat (3000 * UC) @(posedge clk);
        `CK(chirp_k_drive, 1'b0)
        go(1'b0, 1'b0, 0);
        wt(3, 10);
        hs_capable <= 1'b1;
    endtask : t_nohs
    task automatic t_gap();
        @(posedge clk);
        rx_eop <= 1'b1;
        rsp_pending <= 1'b1;
        @(posedge clk);
        rx_eop <= 1'b0;
        wt(5, 80);
        `CK(n >= 21 && n <= 67, 1'b1)
        rx_eop <= 1'b1;
        @(posedge clk);
        rx_eop <= 1'b0;
        repeat (5) @(posedge clk);
        tx_eop <= 1'b1;
        @(posedge clk);
        tx_eop <= 1'b0;
        wt(5, 80);
        `CK(n >= 21 && n <= 67, 1'b1)
        rsp_pending <= 1'b0;
        rx_eop <= 1'b1;
        @(posedge clk);
        rx_eop <= 1'b0;
        wt(6, 90);
        `CK(n >= 66, 1'b1)
    endtask : t_gap
    task automatic t_req(input logic hd, input logic fd, input int ms, input logic e);
        @(posedge clk);
        req <= '{1'b1, hd, 1'b0, fd, 1'b0};
        @(posedge clk);
        req <= '{1'b0, hd, 1'b0, fd, !e};
        @(posedge clk);
        req.done <= 1'b0;
        wt(7, (ms + 2) * 4 * UC, e);
        if (e) `CK(n >= (ms - 1) * 4 * UC, 1'b1)
    endtask : t_req
    initial begin
        rst();
        t_hs();
        rst();
        t_susp();
        t_nohs();
        t_gap();
        t_req(1'b0, 1'b0, 50, 1'b1);
        t_req(1'b1, 1'b0, 500, 1'b1);
        t_req(1'b1, 1'b1, 50, 1'b1);
        t_req(1'b0, 1'b0, 60, 1'b0);
        finish_test();
    end
    initial begin
        #400000;
        err_total++;
        finish_test();
    end
endmodule : tb_top
